// ===== verilog/audio_clock_generator_block.sv
// Audio clock generators, clock output and loop control behind AXI4-Lite
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns

module audio_clock_generator_block
  import clkgen_pkg::*;
#(
  parameter int unsigned LOCK_WAIT = LOCK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Audio clock enables
  output domain_clk_t [DOMAINS-1:0] domain_clk,
  output logic core_sample_pulse,
  // Master clock pin and its pad setup
  output logic master_clock_output_pin,
  output logic [15:0] pad_config,
  // Loop setup seen by the analog side
  output logic [15:0] loop_source,
  output logic [15:0] loop_watchdog,
  // Generator three references
  input wire logic [3:0] gen3_ref_active,
  // Interrupt
  output logic irq
);
  // Bus capture state
  logic aw_held, w_held;
  logic [15:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // Software registers
  logic [15:0] fb_div, pre_div, run_ctl, cout_sel, core_rate;
  logic [15:0] g1n, g1m, g2n, g2m, g3n, g3m, g3src;
  logic [1:0] irq_st, irq_mask;
  // Loop model
  pll_state_t pll_state;
  logic [31:0] lock_cnt;
  logic pll_locked;
  logic [15:0] act_fb;
  // Generator three lock and budget meter
  logic g3_lock;
  logic [31:0] cycle_cnt, instr_budget;
  // Clock output accumulator
  logic [15:0] cout_acc;
  // Generator ticks and configs
  logic [GENS-1:0] gen_tick;
  gen_cfg_t [GENS-1:0] gen_cfg;
  wire domain_clk_t [DOMAINS-1:0] next_domain_clk; // Before the flops
  // Write path accepts address and data in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [15:0] wval = w_data[15:0] & wmask;
  wire wr_fb = do_write && (aw_idx == IDX_FB);
  wire wr_pre = do_write && (aw_idx == IDX_PRE);
  wire wr_src = do_write && (aw_idx == IDX_SRC);
  wire wr_run = do_write && (aw_idx == IDX_RUN);
  wire wr_cout = do_write && (aw_idx == IDX_COUT);
  wire wr_wdog = do_write && (aw_idx == IDX_WDOG);
  wire wr_g1m = do_write && (aw_idx == IDX_G1M);
  wire wr_g1n = do_write && (aw_idx == IDX_G1N);
  wire wr_g2m = do_write && (aw_idx == IDX_G2M);
  wire wr_g2n = do_write && (aw_idx == IDX_G2N);
  wire wr_g3m = do_write && (aw_idx == IDX_G3M);
  wire wr_g3n = do_write && (aw_idx == IDX_G3N);
  wire wr_g3src = do_write && (aw_idx == IDX_G3SRC);
  wire wr_core = do_write && (aw_idx == IDX_CORE);
  wire wr_pad = do_write && (aw_idx == IDX_PAD);
  wire wr_ist = do_write && (aw_idx == IDX_IRQ_ST);
  wire wr_imask = do_write && (aw_idx == IDX_IRQ_MASK);
  // Read-only registers still answer okay; others get an error
  wire wr_mapped = wr_fb | wr_pre | wr_src | wr_run | wr_cout | wr_wdog
    | wr_g1m | wr_g1n | wr_g2m | wr_g2n | wr_g3m | wr_g3n | wr_g3src
    | wr_core | wr_pad | wr_ist | wr_imask
    | (aw_idx == IDX_LOCK) | (aw_idx == IDX_G3LK) | (aw_idx == IDX_BUDGET);
  // Merge of enabled byte lanes into the old value
  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = (old & ~wmask) | wval;
  endfunction
  // Restart only on a zero-to-one step of the run bit
  wire [15:0] run_new = merge(run_ctl);
  wire restart = wr_run && run_new[0] && !run_ctl[0];
  // Channel handshakes of the write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 16'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      // Address capture
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[ADDR_W-1:2];
      end
      // Data capture
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Response once both halves are in
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Register file; loop registers sit at consecutive indices
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_div <= RST_FB;
      pre_div <= RST_PRE;
      loop_source <= 16'h0000;
      run_ctl <= 16'h0000;
      cout_sel <= 16'h0000;
      loop_watchdog <= 16'h0000;
      g1n <= RST_G1N;
      g1m <= RST_G1M;
      g2n <= RST_G2N;
      g2m <= RST_G2M;
      g3n <= RST_G3N;
      g3m <= RST_G3M;
      g3src <= 16'h0000;
      core_rate <= 16'h0000;
      pad_config <= 16'h0000;
      irq_mask <= 2'b00;
    end else begin
      if (wr_fb) fb_div <= merge(fb_div);
      if (wr_pre) pre_div <= merge(pre_div);
      if (wr_src) loop_source <= merge(loop_source);
      if (wr_run) run_ctl <= run_new;
      if (wr_cout) cout_sel <= merge(cout_sel);
      if (wr_wdog) loop_watchdog <= merge(loop_watchdog);
      // Only nine bits are kept for generators one and two
      if (wr_g1n) g1n <= merge(g1n) & GEN12_MASK;
      if (wr_g1m) g1m <= merge(g1m) & GEN12_MASK;
      if (wr_g2n) g2n <= merge(g2n) & GEN12_MASK;
      if (wr_g2m) g2m <= merge(g2m) & GEN12_MASK;
      if (wr_g3n) g3n <= merge(g3n);
      if (wr_g3m) g3m <= merge(g3m);
      if (wr_g3src) g3src <= merge(g3src);
      if (wr_core) core_rate <= merge(core_rate);
      if (wr_pad) pad_config <= merge(pad_config);
      if (wr_imask) irq_mask <= wval[1:0];
    end
  end
  // Read selection
  logic [31:0] rd_val;
  logic rd_ok;
  wire [15:0] ar_idx = s_axi_araddr[ADDR_W-1:2];
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (ar_idx)
      IDX_FB: rd_val[15:0] = fb_div;
      IDX_PRE: rd_val[15:0] = pre_div;
      IDX_SRC: rd_val[15:0] = loop_source;
      IDX_RUN: rd_val[15:0] = run_ctl;
      IDX_LOCK: rd_val[0] = pll_locked;
      IDX_COUT: rd_val[15:0] = cout_sel;
      IDX_WDOG: rd_val[15:0] = loop_watchdog;
      IDX_G1M: rd_val[15:0] = g1m;
      IDX_G1N: rd_val[15:0] = g1n;
      IDX_G2M: rd_val[15:0] = g2m;
      IDX_G2N: rd_val[15:0] = g2n;
      IDX_G3M: rd_val[15:0] = g3m;
      IDX_G3N: rd_val[15:0] = g3n;
      IDX_G3SRC: rd_val[15:0] = g3src;
      IDX_G3LK: rd_val[0] = g3_lock;
      IDX_IRQ_ST: rd_val[1:0] = irq_st;
      IDX_IRQ_MASK: rd_val[1:0] = irq_mask;
      IDX_CORE: rd_val[15:0] = core_rate;
      IDX_BUDGET: rd_val = instr_budget;
      IDX_PAD: rd_val[15:0] = pad_config;
      default: rd_ok = 1'b0;
    endcase
  end
  // Read channel: one answer held until taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Loop lock sequencer; the feedback ratio takes effect at each restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_state <= PLL_IDLE;
      lock_cnt <= 32'h0000_0000;
      act_fb <= RST_FB;
    end else if (restart) begin
      pll_state <= PLL_ACQ;
      lock_cnt <= 32'(LOCK_WAIT - 1);
      act_fb <= fb_div;
    end else begin
      unique case (pll_state)
        PLL_IDLE: ;
        // Wait out the lock time
        PLL_ACQ: begin
          if (!run_ctl[0]) pll_state <= PLL_IDLE;
          else if (lock_cnt == 32'h0000_0000) pll_state <= PLL_LOCKED;
          else lock_cnt <= lock_cnt - 32'h0000_0001;
        end
        PLL_LOCKED: if (!run_ctl[0]) pll_state <= PLL_IDLE;
        default: pll_state <= PLL_IDLE;
      endcase
    end
  end
  assign pll_locked = (pll_state == PLL_LOCKED);
  // Generator ratios; fields beyond the kept width already read zero
  assign gen_cfg[0] = {g1n, g1m};
  assign gen_cfg[1] = {g2n, g2m};
  assign gen_cfg[2] = {g3n, g3m};
  // Each generator ticks at 2048 times its base frame rate
  for (genvar g = 0; g < GENS; g++) begin : gen_g
    logic [16:0] acc;
    logic [TICK_W-1:0] cnt;
    wire [17:0] den18 = {2'b00, gen_cfg[g].den};
    wire [17:0] sum = {1'b0, acc} + {1'b0, gen_cfg[g].num, 1'b0};
    wire [17:0] rem = sum - den18;
    wire wrap = (gen_cfg[g].den != 16'h0000) && (sum >= den18);
    // An over-range ratio saturates at one tick a cycle
    wire [16:0] next_acc = !wrap ? sum[16:0] :
      ((rem >= den18) ? 17'h00000 : rem[16:0]);
    assign gen_tick[g] = wrap && pll_locked;
    // Fractional accumulator and shared tick counter
    always_ff @(posedge aclk) begin
      if (!aresetn || !pll_locked) begin
        acc <= 17'h00000;
        cnt <= '0;
      end else begin
        acc <= next_acc;
        if (wrap) cnt <= cnt + 1'b1;
      end
    end
    // Five rates x4..x1/4 share one counter, so edges line up
    for (genvar d = 0; d < RATES; d++) begin : gen_d
      localparam logic [TICK_W-1:0] FMASK = TICK_W'((1 << (9 + d)) - 1);
      assign next_domain_clk[g*RATES+d].frame =
        gen_tick[g] && ((cnt & FMASK) == '0);
      // Bit enables at 32,64,128,256,512 per frame
      for (genvar b = 0; b < BCLKS; b++) begin : gen_b
        localparam logic [TICK_W-1:0] BMASK =
          TICK_W'((1 << (4 + d - b)) - 1);
        assign next_domain_clk[g*RATES+d].bits[b] =
          gen_tick[g] && ((cnt & BMASK) == '0);
      end
    end
  end
  // One register stage for all domain enables keeps a single driver
  always_ff @(posedge aclk) begin
    if (!aresetn) domain_clk <= '0;
    else domain_clk <= next_domain_clk;
  end
  // Core sample pulse follows the domain chosen by the field
  wire [CORE_W-1:0] core_sel = core_rate[CORE_W-1:0];
  assign core_sample_pulse = (core_sel < CORE_W'(DOMAINS)) &&
    domain_clk[core_sel].frame;
  // Budget: system clocks between core samples; software must
  // loop when it passes program memory size
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_cnt <= 32'h0000_0000;
      instr_budget <= 32'h0000_0000;
    end else if (core_sample_pulse) begin
      instr_budget <= cycle_cnt + 32'h0000_0001;
      cycle_cnt <= 32'h0000_0000;
    end else begin
      cycle_cnt <= cycle_cnt + 32'h0000_0001;
    end
  end
  // Clock output: toggle at 2x mult over the latched feedback ratio
  wire [4:0] cout_step = 5'(2 << cout_sel[1:0]);
  wire [16:0] cout_sum = {1'b0, cout_acc} + {12'h000, cout_step};
  wire cout_tick = pll_locked && (act_fb != 16'h0000) &&
    (cout_sum >= {1'b0, act_fb});
  always_ff @(posedge aclk) begin
    if (!aresetn || !pll_locked) begin
      cout_acc <= 16'h0000;
      master_clock_output_pin <= 1'b0;
    end else if (cout_tick) begin
      cout_acc <= 16'(cout_sum - {1'b0, act_fb});
      master_clock_output_pin <= !master_clock_output_pin;
    end else if (act_fb != 16'h0000) begin
      cout_acc <= cout_sum[15:0];
    end
  end
  // Reference lock of generator three, qualified with no user step
  always_ff @(posedge aclk) begin
    if (!aresetn) g3_lock <= 1'b0;
    else g3_lock <= pll_locked && gen3_ref_active[g3src[1:0]];
  end
  // Sticky events: loop lock gained, generator three lock gained
  wire [1:0] events = {
    pll_locked && gen3_ref_active[g3src[1:0]] && !g3_lock,
    (pll_state == PLL_ACQ) && (lock_cnt == 32'h0000_0000) &&
      run_ctl[0] && !restart};
  wire [1:0] irq_clr = wr_ist ? wval[1:0] : 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_st <= 2'b00;
    else irq_st <= (irq_st & ~irq_clr) | events; // Set wins
  end
  assign irq = |(irq_st & irq_mask);
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  core_out_range_a: assert property (
    core_sel >= CORE_W'(DOMAINS) |-> !core_sample_pulse)
    else $error("core pulse from an unused rate code");
  budget_capture_a: assert property (
    core_sample_pulse |=> instr_budget == $past(cycle_cnt) + 32'h1)
    else $error("budget not equal to cycles per sample");
  bits_at_frame_a: assert property (
    domain_clk[2].frame |-> &domain_clk[2].bits)
    else $error("bit enables missing at frame start");
  rates_aligned_a: assert property (
    domain_clk[2].frame |-> domain_clk[1].frame && domain_clk[0].frame)
    else $error("fast rates not aligned to base frame");
  zero_den_idle_a: assert property (
    gen_cfg[0].den == 16'h0 |-> !gen_tick[0])
    else $error("generator ticks with zero denominator");
  nine_bit_a: assert property (
    g1n[15:9] == 7'h0 && g2m[15:9] == 7'h0)
    else $error("nine-bit ratio holds upper bits");
  reset_defaults_a: assert property (
    disable iff (1'b0) !aresetn |=> fb_div == 16'h60 &&
      pre_div == 16'h4 && g1m == 16'h6 && g2m == 16'h9)
    else $error("wrong value after reset");
  restart_unlock_a: assert property (
    restart |=> pll_state == PLL_ACQ && !pll_locked)
    else $error("run step did not restart the loop");
  lock_after_wait_a: assert property (
    $rose(pll_locked) |-> $past(pll_state) == PLL_ACQ &&
      $past(lock_cnt) == 32'h0)
    else $error("lock flag before wait ended");
  master_clock_output_pin_edge_a: assert property (
    $changed(master_clock_output_pin) && pll_locked |-> $past(cout_tick))
    else $error("clock output moved without a tick");
  g3_needs_loop_a: assert property (
    g3_lock |-> $past(pll_locked))
    else $error("generator three lock without loop lock");
endmodule

// ===== include/clkgen_pkg.sv
// Constants, register indices and carrier types for the audio clock block
package clkgen_pkg;
  // Bus geometry: byte address is four times the register index
  localparam int ADDR_W = 18;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Register indices
  localparam logic [15:0] IDX_FB = 16'hf000;
  localparam logic [15:0] IDX_PRE = 16'hf001;
  localparam logic [15:0] IDX_SRC = 16'hf002;
  localparam logic [15:0] IDX_RUN = 16'hf003;
  localparam logic [15:0] IDX_LOCK = 16'hf004;
  localparam logic [15:0] IDX_COUT = 16'hf005;
  localparam logic [15:0] IDX_WDOG = 16'hf006;
  localparam logic [15:0] IDX_G1M = 16'hf020;
  localparam logic [15:0] IDX_G1N = 16'hf021;
  localparam logic [15:0] IDX_G2M = 16'hf022;
  localparam logic [15:0] IDX_G2N = 16'hf023;
  localparam logic [15:0] IDX_G3M = 16'hf024;
  localparam logic [15:0] IDX_G3N = 16'hf025;
  localparam logic [15:0] IDX_G3SRC = 16'hf026;
  localparam logic [15:0] IDX_G3LK = 16'hf027;
  localparam logic [15:0] IDX_IRQ_ST = 16'hf0f0;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hf0f1;
  localparam logic [15:0] IDX_CORE = 16'hf401;
  localparam logic [15:0] IDX_BUDGET = 16'hf402;
  localparam logic [15:0] IDX_PAD = 16'hf7a3;
  // Values after reset
  localparam logic [15:0] RST_FB = 16'h0060;
  localparam logic [15:0] RST_PRE = 16'h0004;
  localparam logic [15:0] RST_G1N = 16'h0001;
  localparam logic [15:0] RST_G1M = 16'h0006;
  localparam logic [15:0] RST_G2N = 16'h0001;
  localparam logic [15:0] RST_G2M = 16'h0009;
  localparam logic [15:0] RST_G3N = 16'h0001;
  localparam logic [15:0] RST_G3M = 16'h0001;
  // Nine-bit ratio fields of the first two generators
  localparam logic [15:0] GEN12_MASK = 16'h01ff;
  // Core rate field width
  localparam int CORE_W = 5;
  // Structure of the audio clock tree
  localparam int GENS = 3;
  localparam int RATES = 5;
  localparam int DOMAINS = 15;
  localparam int BCLKS = 5;
  localparam int TICK_W = 13;
  // Typical loop lock time and its cycle count at 8 ns
  localparam longint LOCK_TIME_NS = 3500000;
  localparam longint CLK_PERIOD_NS = 8;
  localparam int LOCK_CYCLES = int'(LOCK_TIME_NS / CLK_PERIOD_NS);
  // Loop lock states
  typedef enum logic [2:0] {
    PLL_IDLE = 3'b001,
    PLL_ACQ = 3'b010,
    PLL_LOCKED = 3'b100
  } pll_state_t;
  // One clock domain: frame enable plus 32..512 bit enables
  typedef struct packed {
    logic frame;
    logic [BCLKS-1:0] bits;
  } domain_clk_t;
  // One generator ratio
  typedef struct packed {
    logic [15:0] num;
    logic [15:0] den;
  } gen_cfg_t;
endpackage

// ===== tb/audio_far_side.sv
// Far-side model: reference presence and bit enables counted per frame
`timescale 1ns/1ns
module audio_far_side
  import clkgen_pkg::*;
#(
  parameter int WATCH = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Clock enables from the block
  input wire domain_clk_t [DOMAINS-1:0] domain_clk,
  // References requested by the bench, and the lines they drive
  input wire logic [3:0] ref_on,
  output logic [3:0] gen3_ref_active,
  // Bit enables seen over the last whole frame
  output logic [9:0] per_frame [BCLKS]
);
  logic [9:0] run_cnt [BCLKS]; // Counts since the last frame
  // Reference lines follow the bench request
  assign gen3_ref_active = ref_on;
  // Count bit enables, latch them at each frame enable
  always_ff @(posedge aclk) begin
    for (int b = 0; b < BCLKS; b++) begin
      if (!aresetn) begin
        run_cnt[b] <= '0;
        per_frame[b] <= '0;
      end else if (domain_clk[WATCH].frame) begin
        // Frame cycle carries a bit enable too, so it starts the count
        per_frame[b] <= run_cnt[b];
        run_cnt[b] <= 10'(domain_clk[WATCH].bits[b]);
      end else begin
        run_cnt[b] <= run_cnt[b] + 10'(domain_clk[WATCH].bits[b]);
      end
    end
  end
endmodule

// ===== tb/tb_audio_clock_generator_block.sv
// Register-level testbench for the audio clock generator block
`timescale 1ns/1ns
module tb_audio_clock_generator_block;
  import clkgen_pkg::*;
  localparam int unsigned LW = 20; // Short lock wait keeps the run brief
  // Bus and pin signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  domain_clk_t [DOMAINS-1:0] dclk;
  logic core_pulse, pin, irq;
  logic [15:0] pad, src, wdog;
  logic [3:0] ref_on = 4'h0;
  logic [3:0] ref_act;
  logic [9:0] per_frame [BCLKS];
  // Bookkeeping
  int err_total = 0;
  int samples_checked = 0;
  int n;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [15:0] didx [7] = '{IDX_FB, IDX_PRE, IDX_G1N, IDX_G1M, IDX_G2N,
    IDX_G2M, IDX_LOCK};
  logic [15:0] dval [7] = '{RST_FB, RST_PRE, RST_G1N, RST_G1M, RST_G2N,
    RST_G2M, 16'h0000};

  audio_clock_generator_block #(.LOCK_WAIT(LW)) u_audio_clock_generator_block (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .domain_clk(dclk),
    .core_sample_pulse(core_pulse), .master_clock_output_pin(pin),
    .pad_config(pad), .loop_source(src), .loop_watchdog(wdog),
    .gen3_ref_active(ref_act), .irq(irq));

  audio_far_side u_audio_far_side (
    .aclk(aclk), .aresetn(aresetn), .domain_clk(dclk), .ref_on(ref_on),
    .gen3_ref_active(ref_act), .per_frame(per_frame));

  // Free-running system clock, 8 ns
  initial begin
    forever #4 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One comparison
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  // Write one register; readies and response are sampled mid-cycle
  task automatic wr(input logic [15:0] idx, input logic [15:0] val,
      input logic [1:0] er);
    bit a;
    bit w;
    bit b;
    logic [1:0] r;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 0;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  // Read one register into rd and rsp
  task automatic rdr(input logic [15:0] idx);
    bit a;
    bit r;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    r = 0;
    while (!r) begin
      @(negedge aclk);
      a = arvalid && arready;
      r = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
  endtask

  // Read and compare, response must be OKAY
  task automatic rchk(input string what, input logic [15:0] idx,
      input logic [31:0] exp);
    rdr(idx);
    chk(what, exp, rd);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
  endtask

  // Cycles up to the next core pulse
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (core_pulse !== 1'b1 && c < 40000);
    @(posedge aclk);
  endtask

  // Cycles up to the next toggle of the clock output pin
  task automatic tog(output int c);
    logic p;
    @(negedge aclk);
    p = pin;
    c = 1; // The sampling cycle is the first one of the span
    do begin
      @(negedge aclk);
      c++;
    end while (pin === p && c < 1000);
    @(posedge aclk);
  endtask

  // Hang guard, about twice the expected run length
  initial begin
    #(90000 * 8);
    err_total++;
    summarize;
  end

  // Test sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rchk("default", didx[i], {16'h0, dval[i]});
    end
    $display("test defaults done");
    wr(IDX_G2N, 16'hffff, RESP_OKAY);
    rchk("gen2 num", IDX_G2N, 32'h000001ff);
    wr(IDX_G2N, RST_G2N, RESP_OKAY);
    wr(IDX_G3M, 16'hffff, RESP_OKAY);
    rchk("gen3 den", IDX_G3M, 32'h0000ffff);
    wr(16'hf010, 16'h1234, RESP_SLVERR);
    rdr(16'hf010);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
    wr(IDX_LOCK, 16'h0001, RESP_OKAY);
    rchk("lock ro", IDX_LOCK, 32'h0);
    wr(IDX_PAD, 16'h00a5, RESP_OKAY);
    chk("pad", 32'h00a5, {16'h0, pad});
    wr(IDX_SRC, 16'h0003, RESP_OKAY);
    chk("source", 32'h0003, {16'h0, src});
    wr(IDX_WDOG, 16'h0002, RESP_OKAY);
    chk("watchdog", 32'h0002, {16'h0, wdog});
    $display("test registers done");
    // Lock, interrupt raise, mask and clear
    wr(IDX_IRQ_MASK, 16'h0003, RESP_OKAY);
    wr(IDX_RUN, 16'h0001, RESP_OKAY);
    rchk("lock acq", IDX_LOCK, 32'h0);
    repeat (LW + 5) @(posedge aclk);
    rchk("lock", IDX_LOCK, 32'h1);
    chk("irq set", 32'h1, {31'h0, irq});
    rchk("status", IDX_IRQ_ST, 32'h1);
    wr(IDX_IRQ_MASK, 16'h0002, RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_ST, 16'h0001, RESP_OKAY);
    rchk("status clr", IDX_IRQ_ST, 32'h0);
    wr(IDX_IRQ_MASK, 16'h0003, RESP_OKAY);
    wr(IDX_RUN, 16'h0001, RESP_OKAY);
    rchk("lock kept", IDX_LOCK, 32'h1);
    wr(IDX_PRE, 16'h0002, RESP_OKAY);
    wr(IDX_RUN, 16'h0000, RESP_OKAY);
    rchk("lock drop", IDX_LOCK, 32'h0);
    wr(IDX_RUN, 16'h0001, RESP_OKAY);
    repeat (LW + 5) @(posedge aclk);
    rchk("relock", IDX_LOCK, 32'h1);
    wr(IDX_IRQ_ST, 16'h0003, RESP_OKAY);
    chk("irq clr", 32'h0, {31'h0, irq});
    $display("test loop done");
    // Third generator reference and its lock flag
    wr(IDX_G3SRC, 16'h0001, RESP_OKAY);
    ref_on <= 4'b0010;
    repeat (3) @(posedge aclk);
    rchk("gen3 lock", IDX_G3LK, 32'h1);
    chk("irq gen3", 32'h1, {31'h0, irq});
    ref_on <= 4'b0001;
    repeat (3) @(posedge aclk);
    rchk("gen3 unlock", IDX_G3LK, 32'h0);
    wr(IDX_IRQ_ST, 16'h0003, RESP_OKAY);
    $display("test reference done");
    // Output pin half period is feedback/(2*mult) cycles, feedback 96
    for (int s = 0; s < 4; s++) begin
      wr(IDX_COUT, 16'(s), RESP_OKAY);
      tog(n);
      tog(n);
      chk("master_clock_output_pin half", 32'(48 >> s), 32'(n));
    end
    $display("test clock out done");
    // Gen3 N=1 M=2: base 2048 cycles, domains x4 x2 base half quarter
    wr(IDX_G3M, 16'h0002, RESP_OKAY);
    wr(IDX_G3N, 16'h0001, RESP_OKAY);
    for (int c = 10; c < 15; c++) begin
      wr(IDX_CORE, 16'(c), RESP_OKAY);
      gap(n);
      gap(n);
      chk("frame gap", 32'(512 << (c - 10)), 32'(n));
      rchk("budget", IDX_BUDGET, 32'(512 << (c - 10)));
    end
    for (int b = 0; b < BCLKS; b++) begin
      chk("bits per frame", 32'(32 << b), {22'h0, per_frame[b]});
    end
    // Upper field bits must not disturb code 2, gen1 base 48k at 294.912
    wr(IDX_CORE, 16'hffe2, RESP_OKAY);
    gap(n);
    gap(n);
    chk("core gap", 32'd6144, 32'(n));
    rchk("budget gen1", IDX_BUDGET, 32'd6144);
    $display("test rates done");
    summarize;
  end
endmodule
